/* kpirq_pkg.sv */
`default_nettype none
package kpirq_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] KP_OFF_CLEAR = 8'h08;
  localparam logic [7:0] KP_OFF_MASK = 8'h09;
  localparam logic [7:0] KP_OFF_SLOT0 = 8'h0B;
  localparam logic [7:0] KP_OFF_SLOT3 = 8'h0E;

  // ==========================================================================
  // Field positions
  localparam int KP_CLR_SCAN_BIT = 0;
  localparam int KP_CLR_EVT_BIT = 1;
  localparam int KP_CLR_SPECIAL_KEY_SCAN_OFF_BIT = 7;
  // Raw and mask bits share these positions.
  localparam int KP_IRQ_SCAN = 0;
  localparam int KP_IRQ_LOST = 1;
  localparam int KP_IRQ_EVT = 2;
  localparam int KP_IRQ_ELOST = 3;

  // ==========================================================================
  // Reset values and codes
  localparam logic [3:0] KP_MASK_RST = 4'h3;
  localparam logic [3:0] KP_MASK_W = 4'hF;
  localparam logic [2:0] KP_ROW_NONE = 3'h7;
  localparam logic [3:0] KP_COL_NONE = 4'hF;
  localparam logic [3:0] KP_COL_SF = 4'hC;
  localparam logic [3:0] KP_COL_BALL_A = 4'hD;
  localparam logic [3:0] KP_COL_BALL_B = 4'hE;
  localparam logic [7:0] KP_SLOT_EMPTY = 8'h7F;
  localparam int KP_SLOTS = 4;
  localparam int KP_EVT_DEPTH = 16;
  localparam int KP_CNT_W = 5;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] row;
    logic [3:0] col;
  } kp_code_t;

  typedef struct packed {
    logic more;
    kp_code_t code;
  } kp_slot_t;

  typedef struct packed {
    logic over_four;
    logic [2:0] count;
    kp_code_t [3:0] keys;
  } kp_report_t;

  typedef struct packed {
    logic release_key;
    kp_code_t code;
  } kp_event_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } kp_reg_req_t;

  typedef struct packed {
    logic sf_off;
    logic [3:0] mask;
    logic [3:0] raw;
    kp_slot_t [3:0] slots;
    kp_report_t last;
    logic [3:0] rd_seen;
    logic [KP_CNT_W-1:0] evt_count;
    logic evt_clear;
    logic push;
    kp_event_t push_data;
    logic [7:0] rdata;
    logic irq;
  } kp_state_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] sf_sync;
  } kp_link_state_t;

endpackage
`default_nettype wire

/* kpirq_xfer.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Word crossing by toggle handshake.
// The source word is held until the far side has acknowledged, so the
// destination may sample it without a gray code; the price is one word in flight.
module kpirq_xfer #(
  parameter int WIDTH = 8
) (
  // Source side
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic src_valid_i,
  input wire logic [WIDTH-1:0] src_data_i,
  output logic src_ready_o,
  // Destination side
  input wire logic dst_clk_i,
  input wire logic dst_rst_n_i,
  output logic dst_valid_o,
  output logic [WIDTH-1:0] dst_data_o
);

  typedef struct packed {
    logic req;
    logic [1:0] ack_sync;
    logic [WIDTH-1:0] hold;
  } kpx_src_t;

  typedef struct packed {
    logic [1:0] req_sync;
    logic seen;
    logic valid;
    logic [WIDTH-1:0] data;
  } kpx_dst_t;

  kpx_src_t src_reg;
  kpx_src_t src_next;
  kpx_dst_t dst_reg;
  kpx_dst_t dst_next;

  assign src_ready_o = (src_reg.req == src_reg.ack_sync[1]);
  assign dst_valid_o = dst_reg.valid;
  assign dst_data_o = dst_reg.data;

  // ==========================================================================
  // Source domain
  always_comb begin
    src_next = src_reg;
    src_next.ack_sync = {src_reg.ack_sync[0], dst_reg.seen};
    if (src_valid_i && src_ready_o) begin
      src_next.req = ~src_reg.req;
      src_next.hold = src_data_i;
    end
    if (!src_rst_n_i) begin
      src_next = '0;
    end
  end

  always_ff @(posedge src_clk_i) begin
    src_reg <= src_next;
  end

  // ==========================================================================
  // Destination domain
  always_comb begin
    dst_next = dst_reg;
    dst_next.req_sync = {dst_reg.req_sync[0], src_reg.req};
    dst_next.valid = 1'b0;
    if (dst_reg.req_sync[1] != dst_reg.seen) begin
      dst_next.seen = dst_reg.req_sync[1];
      dst_next.valid = 1'b1;
      dst_next.data = src_reg.hold;
    end
    if (!dst_rst_n_i) begin
      dst_next = '0;
    end
  end

  always_ff @(posedge dst_clk_i) begin
    dst_reg <= dst_next;
  end

endmodule
`default_nettype wire

/* kpirq_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Clear bit 7 set skips special-function key scanning.
// - Clear bit 1 empties events, clears event interrupts.
// - Press during event clear records only release.
// - Clear bit 0 clears scan-change and key-lost.
// - Scan clear leaves key-code slots untouched.
// - Masked interrupts never drive interrupt output.
// - Mask bit 3 gates event-lost, resets 0.
// - Mask bit 2 gates key event, resets 0.
// - Mask bit 1 gates key-lost, resets 1.
// - Mask bit 0 gates scan-change, resets 1.
// - At most four keys, one per slot.
// - Reading all four slots clears scan-change.
// - Slot 0 reads 0x7F with no key.
// - Slot: more flag, row, column fields.
// - Columns: matrix, special key, column-ball keys.
// - More flag announces key in next slot.
// - Scan-change raised only when keyboard changed.
// - Key-lost on uncleared change or five keys.
// - Event-lost when seventeenth event overflows buffer.
// - Event interrupt follows buffered event count.
module kpirq_regs #(
  parameter int EVT_DEPTH = kpirq_pkg::KP_EVT_DEPTH
) (
  // System clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register access from the serial front end
  input wire kpirq_pkg::kp_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Scan engine, link clock domain
  input wire logic scan_clk_i,
  input wire logic scan_report_valid_i,
  input wire kpirq_pkg::kp_report_t scan_report_i,
  output logic scan_report_ready_o,
  input wire logic key_event_valid_i,
  input wire kpirq_pkg::kp_event_t key_event_i,
  output logic key_event_ready_o,
  output logic special_key_scan_off_o,
  // Event FIFO side
  input wire logic event_pop_i,
  output logic event_push_o,
  output kpirq_pkg::kp_event_t event_data_o,
  output logic event_fifo_clear_o,
  // Status
  output logic [3:0] raw_status_o,
  output logic keypad_irq_o
);

  kpirq_pkg::kp_state_t st_reg;
  kpirq_pkg::kp_state_t st_next;
  kpirq_pkg::kp_link_state_t lk_reg;
  kpirq_pkg::kp_link_state_t lk_next;
  logic link_rst_n;
  logic rpt_valid;
  kpirq_pkg::kp_report_t rpt;
  logic ev_valid;
  kpirq_pkg::kp_event_t ev;
  logic wr_clear;
  logic wr_mask;
  logic clr_scan;
  logic clr_evt;
  logic slot_rd;
  logic [1:0] slot_idx;

  // ==========================================================================
  // Helpers
  function automatic logic kp_is_slot(input logic [7:0] addr);
    return (addr >= kpirq_pkg::KP_OFF_SLOT0) && (addr <= kpirq_pkg::KP_OFF_SLOT3);
  endfunction

  // Column codes pass through unchanged: 0 to 11 matrix, 12 special, 13 and 14 balls.
  function automatic kpirq_pkg::kp_slot_t kp_fill(input kpirq_pkg::kp_report_t r,
                                                  input int idx);
    kpirq_pkg::kp_slot_t s;
    s = kpirq_pkg::KP_SLOT_EMPTY;
    if (idx < int'(r.count)) begin
      s.code = r.keys[idx];
      if (idx == kpirq_pkg::KP_SLOTS - 1) begin
        s.more = r.over_four;
      end else begin
        s.more = (idx + 1 < int'(r.count));
      end
    end
    return s;
  endfunction

  // ==========================================================================
  // Link domain: reset release and the special-key scan control.
  assign link_rst_n = lk_reg.rst_sync[1];
  assign special_key_scan_off_o = lk_reg.sf_sync[1];

  always_comb begin
    lk_next = lk_reg;
    lk_next.rst_sync = {lk_reg.rst_sync[0], rst_n_i};
    lk_next.sf_sync = {lk_reg.sf_sync[0], st_reg.sf_off};
    if (!link_rst_n) begin
      lk_next.sf_sync = '0;
    end
  end

  always_ff @(posedge scan_clk_i) begin
    lk_reg <= lk_next;
  end

  // ==========================================================================
  // Crossings from the scan engine.
  kpirq_xfer #(
    .WIDTH($bits(kpirq_pkg::kp_report_t))
  ) u_report_xfer (
    .src_clk_i(scan_clk_i),
    .src_rst_n_i(link_rst_n),
    .src_valid_i(scan_report_valid_i),
    .src_data_i(scan_report_i),
    .src_ready_o(scan_report_ready_o),
    .dst_clk_i(clock_i),
    .dst_rst_n_i(rst_n_i),
    .dst_valid_o(rpt_valid),
    .dst_data_o(rpt)
  );

  kpirq_xfer #(
    .WIDTH($bits(kpirq_pkg::kp_event_t))
  ) u_event_xfer (
    .src_clk_i(scan_clk_i),
    .src_rst_n_i(link_rst_n),
    .src_valid_i(key_event_valid_i),
    .src_data_i(key_event_i),
    .src_ready_o(key_event_ready_o),
    .dst_clk_i(clock_i),
    .dst_rst_n_i(rst_n_i),
    .dst_valid_o(ev_valid),
    .dst_data_o(ev)
  );

  // ==========================================================================
  // Register decode
  always_comb begin
    wr_clear = 1'b0;
    wr_mask = 1'b0;
    if (reg_req_i.wr && reg_req_i.addr == kpirq_pkg::KP_OFF_CLEAR) begin
      wr_clear = 1'b1;
    end else if (reg_req_i.wr && reg_req_i.addr == kpirq_pkg::KP_OFF_MASK) begin
      wr_mask = 1'b1;
    end
  end

  assign clr_scan = wr_clear && reg_req_i.wdata[kpirq_pkg::KP_CLR_SCAN_BIT];
  assign clr_evt = wr_clear && reg_req_i.wdata[kpirq_pkg::KP_CLR_EVT_BIT];
  assign slot_rd = reg_req_i.rd && kp_is_slot(reg_req_i.addr);
  assign slot_idx = 2'(reg_req_i.addr - kpirq_pkg::KP_OFF_SLOT0);

  // ==========================================================================
  // System domain state
  localparam int KP_CW = kpirq_pkg::KP_CNT_W;
  localparam logic [KP_CW-1:0] KP_CNT_ONE = KP_CW'(1);
  localparam logic [KP_CW-1:0] KP_CNT_FULL = KP_CW'(EVT_DEPTH);

  always_comb begin
    st_next = st_reg;
    st_next.push = 1'b0;
    st_next.evt_clear = clr_evt;
    if (wr_clear) begin
      st_next.sf_off = reg_req_i.wdata[kpirq_pkg::KP_CLR_SPECIAL_KEY_SCAN_OFF_BIT];
    end
    if (wr_mask) begin
      st_next.mask = reg_req_i.wdata[3:0];
    end
    // Clears act first so that a coincident set wins.
    if (clr_scan) begin
      st_next.raw[kpirq_pkg::KP_IRQ_SCAN] = 1'b0;
      st_next.raw[kpirq_pkg::KP_IRQ_LOST] = 1'b0;
    end
    if (slot_rd) begin
      st_next.rd_seen[slot_idx] = 1'b1;
      if (&st_next.rd_seen) begin
        st_next.raw[kpirq_pkg::KP_IRQ_SCAN] = 1'b0;
        st_next.raw[kpirq_pkg::KP_IRQ_LOST] = 1'b0;
        st_next.rd_seen = '0;
      end
    end
    if (rpt_valid && rpt != st_reg.last) begin
      st_next.raw[kpirq_pkg::KP_IRQ_SCAN] = 1'b1;
      if (st_reg.raw[kpirq_pkg::KP_IRQ_SCAN]) begin
        st_next.raw[kpirq_pkg::KP_IRQ_LOST] = 1'b1;
      end
      st_next.last = rpt;
      st_next.rd_seen = '0;
      for (int i = 0; i < kpirq_pkg::KP_SLOTS; i++) begin
        st_next.slots[i] = kp_fill(rpt, i);
      end
    end
    if (rpt_valid && rpt.over_four) begin
      st_next.raw[kpirq_pkg::KP_IRQ_LOST] = 1'b1;
    end
    // Event buffer bookkeeping; contents live in the outside FIFO.
    if (clr_evt) begin
      st_next.evt_count = '0;
      st_next.raw[kpirq_pkg::KP_IRQ_ELOST] = 1'b0;
    end else if (event_pop_i && st_reg.evt_count != '0) begin
      st_next.evt_count = st_reg.evt_count - KP_CNT_ONE;
    end
    if (ev_valid && !((clr_evt || st_reg.evt_clear) && !ev.release_key)) begin
      if (st_next.evt_count == KP_CNT_FULL) begin
        st_next.raw[kpirq_pkg::KP_IRQ_ELOST] = 1'b1;
      end else begin
        st_next.evt_count = st_next.evt_count + KP_CNT_ONE;
        st_next.push = 1'b1;
        st_next.push_data = ev;
      end
    end
    st_next.raw[kpirq_pkg::KP_IRQ_EVT] = (st_next.evt_count != '0);
    if (reg_req_i.rd) begin
      st_next.rdata = '0;
      if (reg_req_i.addr == kpirq_pkg::KP_OFF_MASK) begin
        st_next.rdata = {4'h0, st_reg.mask};
      end else if (kp_is_slot(reg_req_i.addr)) begin
        st_next.rdata = st_reg.slots[slot_idx];
      end
    end
    st_next.irq = |(st_next.raw & ~st_next.mask);
    if (!rst_n_i) begin
      st_next = '0;
      st_next.mask = kpirq_pkg::KP_MASK_RST;
      for (int i = 0; i < kpirq_pkg::KP_SLOTS; i++) begin
        st_next.slots[i] = kpirq_pkg::KP_SLOT_EMPTY;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    st_reg <= st_next;
  end

  assign reg_rdata_o = st_reg.rdata;
  assign raw_status_o = st_reg.raw;
  assign keypad_irq_o = st_reg.irq;
  assign event_push_o = st_reg.push;
  assign event_data_o = st_reg.push_data;
  assign event_fifo_clear_o = st_reg.evt_clear;

  // ==========================================================================
  // Checks
  sequence scan_clear_seq;
    clr_scan && !rpt_valid && !slot_rd;
  endsequence

  sequence evt_clear_seq;
    clr_evt && !ev_valid;
  endsequence

  mask_reset_a: assert property (@(posedge clock_i) $rose(rst_n_i) |->
    st_reg.mask == kpirq_pkg::KP_MASK_RST)
    else $error("mask reset value wrong");

  mask_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (wr_mask && reg_req_i.wdata[3:0] == kpirq_pkg::KP_MASK_W) |=> !keypad_irq_o)
    else $error("masked interrupt reached output");

  scan_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    scan_clear_seq |=> !raw_status_o[kpirq_pkg::KP_IRQ_SCAN]
      && !raw_status_o[kpirq_pkg::KP_IRQ_LOST])
    else $error("scan clear did not clear");

  slots_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    scan_clear_seq |=> $stable(st_reg.slots))
    else $error("slots changed by scan clear");

  evt_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    evt_clear_seq |=> st_reg.evt_count == '0 && !raw_status_o[kpirq_pkg::KP_IRQ_ELOST]
      ##1 !raw_status_o[kpirq_pkg::KP_IRQ_EVT] || st_reg.evt_count != '0)
    else $error("event clear failed");

  press_drop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clr_evt && ev_valid && !ev.release_key) |=> !event_push_o)
    else $error("press during clear was recorded");

  all_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (slot_rd && (st_reg.rd_seen | (4'h1 << slot_idx)) == 4'hF && !rpt_valid)
      |=> !raw_status_o[kpirq_pkg::KP_IRQ_SCAN])
    else $error("reading all slots left scan interrupt");

  empty_slot_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rpt_valid && rpt.count == 3'h0 && rpt != st_reg.last)
      |=> st_reg.slots[0] == kpirq_pkg::KP_SLOT_EMPTY)
    else $error("empty slot 0 not 0x7F");

  more_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rpt_valid && rpt.count >= 3'h2 && rpt != st_reg.last)
      |=> st_reg.slots[0].more && st_reg.slots[0].code == $past(rpt.keys[0]))
    else $error("more flag of slot 0 missing");

  lost_four_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rpt_valid && rpt.over_four) |=> raw_status_o[kpirq_pkg::KP_IRQ_LOST])
    else $error("over four keys not flagged");

  evt_overflow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ev_valid && st_reg.evt_count == KP_CNT_FULL && !event_pop_i && !clr_evt)
      |=> raw_status_o[kpirq_pkg::KP_IRQ_ELOST] && !event_push_o)
    else $error("overflow not flagged");

  evt_irq_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (ev_valid && ev.release_key && st_reg.evt_count == '0 && !clr_evt && !st_reg.evt_clear)
      |=> raw_status_o[kpirq_pkg::KP_IRQ_EVT] && event_push_o)
    else $error("event interrupt not raised");

  sf_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_clear |=> st_reg.sf_off == $past(reg_req_i.wdata[kpirq_pkg::KP_CLR_SPECIAL_KEY_SCAN_OFF_BIT]))
    else $error("special key scan control not stored");

  sequence new_report_seq;
    rpt_valid && rpt != st_reg.last;
  endsequence

  slot_reset_a: assert property (@(posedge clock_i) $rose(rst_n_i) |->
    st_reg.slots[0] == kpirq_pkg::KP_SLOT_EMPTY
      && st_reg.slots[3] == kpirq_pkg::KP_SLOT_EMPTY)
    else $error("key-code slot reset value wrong");

  mask_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_mask |=> st_reg.mask == $past(reg_req_i.wdata[3:0]))
    else $error("mask write not stored");

  mask_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (reg_req_i.rd && reg_req_i.addr == kpirq_pkg::KP_OFF_MASK)
      |=> reg_rdata_o == {4'h0, $past(st_reg.mask)})
    else $error("mask read back wrong");

  irq_raise_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (new_report_seq ##0 !st_reg.mask[kpirq_pkg::KP_IRQ_SCAN] && !wr_mask) |=> keypad_irq_o)
    else $error("unmasked scan change did not raise interrupt");

  slot_last_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (new_report_seq ##0 rpt.count >= 3'(kpirq_pkg::KP_SLOTS))
      |=> st_reg.slots[3].code == $past(rpt.keys[3])
      && st_reg.slots[3].more == $past(rpt.over_four))
    else $error("fourth key-code slot wrong");

  same_report_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rpt_valid && rpt == st_reg.last && !slot_rd && !wr_clear)
      |=> raw_status_o[kpirq_pkg::KP_IRQ_SCAN] == $past(raw_status_o[kpirq_pkg::KP_IRQ_SCAN]))
    else $error("unchanged scan raised scan change");

  evt_drain_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (event_pop_i && st_reg.evt_count == KP_CNT_ONE && !ev_valid && !clr_evt)
      |=> !raw_status_o[kpirq_pkg::KP_IRQ_EVT])
    else $error("event interrupt stayed after last pop");

endmodule
`default_nettype wire

/* kpirq_scan_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Scan engine stand-in on the link clock.
// Between words the data lines carry the inverse of the last word, so a design
// that samples outside the handshake reads garbage instead of a lucky copy.
module kpirq_scan_model (
  // Link clock
  input wire logic scan_clk_i,
  // Report handshake
  input wire logic rpt_ready_i,
  output logic rpt_valid_o,
  output kpirq_pkg::kp_report_t rpt_o,
  // Event handshake
  input wire logic evt_ready_i,
  output logic evt_valid_o,
  output kpirq_pkg::kp_event_t evt_o
);
  initial begin
    rpt_valid_o = 1'b0;
    rpt_o = '0;
    evt_valid_o = 1'b0;
    evt_o = '0;
  end

  // A gap of idle link cycles lets a test offer words slowly as well as promptly.
  task automatic send_report(input kpirq_pkg::kp_report_t r, input int gap);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge scan_clk_i);
    rpt_valid_o <= 1'b1;
    rpt_o <= r;
    do begin
      @(posedge scan_clk_i);
      n++;
    end while (!rpt_ready_i && n < 200);
    rpt_valid_o <= 1'b0;
    rpt_o <= ~r;
    do begin
      @(posedge scan_clk_i);
      n++;
    end while (!rpt_ready_i && n < 400);
  endtask

  task automatic send_event(input kpirq_pkg::kp_event_t e, input int gap);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge scan_clk_i);
    evt_valid_o <= 1'b1;
    evt_o <= e;
    do begin
      @(posedge scan_clk_i);
      n++;
    end while (!evt_ready_i && n < 200);
    evt_valid_o <= 1'b0;
    evt_o <= ~e;
    do begin
      @(posedge scan_clk_i);
      n++;
    end while (!evt_ready_i && n < 400);
  endtask
endmodule
`default_nettype wire

/* keypad_irq_keycode_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module keypad_irq_keycode_regs_tb;
  // ==========================================================================
  // Signals
  logic clock_i = 1'b0;
  logic scan_clk = 1'b0;
  logic rst_n = 1'b0;
  logic event_pop = 1'b0;
  kpirq_pkg::kp_reg_req_t req = '0;
  logic [7:0] rdata;
  logic rpt_ready, rpt_valid, evt_ready, evt_valid, sf_off, push, fifo_clr, irq;
  logic [3:0] raw;
  kpirq_pkg::kp_report_t rpt, ra, rb;
  kpirq_pkg::kp_event_t evt, evt_out, last_evt;
  logic [7:0] got;
  int n_fail = 0;
  int checked = 0;
  int n_push = 0;
  int n_clr = 0;

  always #20 clock_i = ~clock_i;
  initial begin
    #7;
    forever #32 scan_clk = ~scan_clk;
  end

  kpirq_regs dut_u (.clock_i(clock_i), .rst_n_i(rst_n), .reg_req_i(req), .reg_rdata_o(rdata),
    .scan_clk_i(scan_clk), .scan_report_valid_i(rpt_valid), .scan_report_i(rpt),
    .scan_report_ready_o(rpt_ready), .key_event_valid_i(evt_valid), .key_event_i(evt),
    .key_event_ready_o(evt_ready), .special_key_scan_off_o(sf_off), .event_pop_i(event_pop),
    .event_push_o(push), .event_data_o(evt_out), .event_fifo_clear_o(fifo_clr),
    .raw_status_o(raw), .keypad_irq_o(irq));
  kpirq_scan_model scan_u (.scan_clk_i(scan_clk), .rpt_ready_i(rpt_ready),
    .rpt_valid_o(rpt_valid), .rpt_o(rpt), .evt_ready_i(evt_ready), .evt_valid_o(evt_valid),
    .evt_o(evt));

  // Stands in for the outside event FIFO: counts pushes and clears.
  always @(posedge clock_i) begin
    if (push) begin
      n_push <= n_push + 1;
      last_evt <= evt_out;
    end
    if (fifo_clr) begin
      n_clr <= n_clr + 1;
    end
  end

  // ==========================================================================
  // Access tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req <= '0;
    cyc(2);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req <= '0;
    #1;
    chk(rdata, e, $sformatf("read %h", a));
  endtask
  task automatic chk_st(input logic [3:0] r, input logic i);
    chk({4'h0, raw}, {4'h0, r}, "raw status");
    chk({7'h00, irq}, {7'h00, i}, "irq line");
  endtask
  function automatic logic [7:0] exp_slot(input kpirq_pkg::kp_report_t r, input int k);
    if (k >= int'(r.count)) return 8'h7F;
    if (k == 3) return {r.over_four, r.keys[3]};
    return {k + 1 < int'(r.count), r.keys[k]};
  endfunction
  task automatic chk_slots(input kpirq_pkg::kp_report_t r);
    for (int k = 0; k < 4; k++) chk_rd(8'h0B + 8'(k), exp_slot(r, k));
  endtask
  task automatic send_rpt(input kpirq_pkg::kp_report_t r, input int gap);
    scan_u.send_report(r, gap);
    cyc(4);
  endtask
  task automatic send_evt(input kpirq_pkg::kp_event_t e);
    scan_u.send_event(e, 0);
    cyc(4);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    results();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n <= 1'b1;
    cyc(4);
    chk_rd(8'h09, 8'h03);
    chk_slots(mkr0());
    chk_rd(8'h08, 8'h00);
    chk_rd(8'h0A, 8'h00);
    chk_st(4'h0, 1'b0);
    $display("test reset done");
    wr_reg(8'h09, 8'hFF);
    chk_rd(8'h09, 8'h0F);
    wr_reg(8'h09, 8'h0E);
    ra = {1'b0, 3'd3, 7'h55, 3'd3, 4'hE, 3'd7, 4'hD, 3'd0, 4'hC};
    send_rpt(ra, 0);
    chk_st(4'h1, 1'b1);
    wr_reg(8'h09, 8'h0F);
    chk_st(4'h1, 1'b0);
    wr_reg(8'h09, 8'h0E);
    chk_rd(8'h0B, 8'h8C);
    chk_rd(8'h0C, 8'hFD);
    wr_reg(8'h08, 8'h01);
    chk_st(4'h0, 1'b0);
    chk_rd(8'h0B, 8'h8C);
    chk_rd(8'h0D, 8'h3E);
    send_rpt(ra, 3);
    chk_st(4'h0, 1'b0);
    $display("test scan change done");
    wr_reg(8'h09, 8'h0D);
    rb = {1'b1, 3'd4, 3'd6, 4'h2, 3'd5, 4'hB, 3'd2, 4'h1, 3'd1, 4'h0};
    send_rpt(rb, 1);
    chk_st(4'h3, 1'b1);
    chk_slots(rb);
    cyc(2);
    chk_st(4'h0, 1'b0);
    send_rpt({1'b0, 3'd1, 21'h0, 3'd4, 4'h5}, 0);
    send_rpt(mkr0(), 0);
    chk_st(4'h3, 1'b1);
    chk_rd(8'h0B, 8'h7F);
    wr_reg(8'h08, 8'h01);
    chk_st(4'h0, 1'b0);
    $display("test key lost done");
    wr_reg(8'h09, 8'h03);
    send_evt({1'b0, 3'd2, 4'h3});
    chk(8'(n_push), 8'h01, "push count");
    chk(last_evt, 8'h23, "pushed event");
    chk_st(4'h4, 1'b1);
    @(posedge clock_i);
    event_pop <= 1'b1;
    @(posedge clock_i);
    event_pop <= 1'b0;
    cyc(2);
    chk_st(4'h0, 1'b0);
    for (int i = 0; i < 16; i++) send_evt({1'b1, 3'(i % 8), 4'(i % 12)});
    chk_st(4'h4, 1'b1);
    send_evt({1'b1, 3'd1, 4'h1});
    chk(8'(n_push), 8'h11, "push count");
    chk_st(4'hC, 1'b1);
    wr_reg(8'h09, 8'h07);
    chk_st(4'hC, 1'b1);
    wr_reg(8'h09, 8'h0F);
    chk_st(4'hC, 1'b0);
    wr_reg(8'h08, 8'h02);
    chk(8'(n_clr), 8'h01, "fifo clear count");
    chk_st(4'h0, 1'b0);
    $display("test events done");
    wr_reg(8'h08, 8'h80);
    cyc(12);
    chk({7'h00, sf_off}, 8'h01, "special key scan off");
    wr_reg(8'h08, 8'h00);
    cyc(12);
    chk({7'h00, sf_off}, 8'h00, "special key scan on");
    $display("test special keys done");
    results();
  end

  // An empty report: no keys down.
  function automatic kpirq_pkg::kp_report_t mkr0();
    return '0;
  endfunction
endmodule
`default_nettype wire
